// ---- src/dsm_ctrl.sv ----
// driver operating state, power-on defaults, output gating and mode control
// assumes decoded spi words arrive as same-clock strobes; pins are asynchronous
//
// Contract
// [RULE1] both supplies present: run power-on reset, then go normal
// [RULE2] power-on reset is filtered against short supply transients
// [RULE3] gate outputs off in power-on reset and sleep states
// [RULE4] output gate pin high forces every output off
// [RULE5] spi stays active while output gate pin high
// [RULE6] gate pin low: outputs follow command bit or parallel input
// [RULE7] logic supply lost: sleep with outputs off; return via power-on reset
// [RULE8] reset defaults: outputs off, ignition mode, pwm off, open-load detect on
// [RULE9] reset defaults: max 14 A, nominal 5.5 A, end spark supply+5.5 V
// [RULE10] reset defaults: open secondary 100 us, max dwell 32 ms
// [RULE11] reset defaults: soft shutdown, low clamp, overlap offset disabled
// [RULE12] four gate drivers each select ignition, general or ten-cylinder mode; drivers pick only ignition or general, one ten-cylinder bit covers all
// [RULE13] mode word holds mode bits, ten-cylinder, retry and pwm enables
// [RULE14] mode bits 8..11 pick driver 0..3; 1 is general purpose
// [RULE15] general purpose drivers still obey max-current shutdown
// [RULE16] ten-cylinder mode turns both current flag pins into inputs
// [RULE17] ten-cylinder: max flag stops drivers 0,2; nominal flag stops 1,3
// [RULE18] battery over or under voltage commands every output off
// [RULE19] retry bit 1: stay off after recovery until input toggles
// [RULE20] retry bit 0: resume commanded state after recovery, gate pin low
// [RULE21] spi bit drives a gate driver only in general purpose mode
// [RULE22] logic undervoltage shuts outputs and restores register defaults
// [RULE23] mode bits 0..3 enable pwm of general purpose drivers 0..3
// [RULE24] parallel input ored with spi bit; ignition drivers use input only
// [RULE25] ten-cylinder and retry bit positions are parameters
`timescale 1ns/1ns
`include "dsm_params.svh"
module dsm_ctrl #(
	parameter int N_CH       = 4,
	parameter int POR_CYC    = `DSM_POR_FILTER_CYC,
	parameter int V10_BIT    = `DSM_V10_BIT,   // see [RULE25]
	parameter int RETRY_BIT  = `DSM_RETRY_BIT  // see [RULE25]
) (
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_battery_supply_ok,
	input  wire logic                   i_logic_supply_ok,
	input  wire logic                   i_battery_fault,
	input  wire logic                   i_output_gate_n,
	input  wire logic [N_CH-1:0]        i_gate_parallel_inputs,
	input  wire logic [N_CH-1:0]        i_injector_parallel_inputs,
	input  wire logic                   i_spi_cmd_wr,
	input  wire logic [2*N_CH-1:0]      i_spi_cmd,
	input  wire logic                   i_mode_wr,
	input  wire logic [`DSM_MODE_W-1:0] i_mode_word,
	input  wire logic [N_CH-1:0]        i_max_current_cmp,
	input  wire logic [N_CH-1:0]        i_nominal_current_cmp,
	input  wire logic [N_CH-1:0]        i_pwm_wave,
	input  wire logic                   i_max_current_flag_in,
	input  wire logic                   i_nominal_current_flag_in,
	output logic      [N_CH-1:0]        o_gate_drive_outputs,
	output logic      [N_CH-1:0]        o_injector_outputs,
	output logic                        o_max_current_flag,
	output logic                        o_max_current_flag_oe,
	output logic                        o_nominal_current_flag,
	output logic                        o_nominal_current_flag_oe,
	output logic      [N_CH-1:0]        o_general_gate_mode,
	output logic                        o_ten_cylinder_mode,
	output logic      [N_CH-1:0]        o_pwm_enable,
	output logic                        o_open_load_detect_en,
	output logic      [1:0]             o_max_dac_sel,
	output logic      [1:0]             o_nom_dac_sel,
	output logic      [1:0]             o_end_spark_sel,
	output logic      [1:0]             o_open_sec_sel,
	output logic      [2:0]             o_dwell_sel,
	output logic                        o_soft_shutdown_en,
	output logic                        o_low_clamp_en,
	output logic                        o_overlap_offset_en,
	output logic                        o_spi_ready,
	output dsm_pkg::dsm_state_t         o_state
);
	localparam int NO = 2 * N_CH;
	localparam int PW = $clog2(POR_CYC + 1);

	// pin synchronisers: first stage read only by the second
	localparam int NS = 5 + 2 * N_CH + 2;
	logic [NS-1:0] sync1;
	logic [NS-1:0] sync2;
	wire  [NS-1:0] raw_pins = {i_battery_supply_ok, i_logic_supply_ok, i_battery_fault,
		i_output_gate_n, 1'b0, i_gate_parallel_inputs, i_injector_parallel_inputs,
		i_max_current_flag_in, i_nominal_current_flag_in};
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= raw_pins;
			sync2 <= sync1;
		end
	end
	wire            bat_ok   = sync2[NS-1];
	wire            vdd_ok   = sync2[NS-2];
	wire            bat_flt  = sync2[NS-3];
	wire            gate_n   = sync2[NS-4];
	wire [N_CH-1:0] gin      = sync2[2+2*N_CH-1:2+N_CH];
	wire [N_CH-1:0] din      = sync2[2+N_CH-1:2];
	wire            max_current_flag_in  = sync2[1];
	wire            nominal_current_flag_in  = sync2[0];

	// operating state
	dsm_pkg::dsm_state_t state;
	dsm_pkg::dsm_state_t next_state;
	logic [PW-1:0]       por_cnt;
	wire por_done = (por_cnt == PW'(POR_CYC));
	always_comb begin
		next_state = state;
		case (state)
			dsm_pkg::DSM_POWER_OFF:
				if (bat_ok || vdd_ok) next_state = dsm_pkg::DSM_POR;
			dsm_pkg::DSM_POR: begin
				if (!vdd_ok && bat_ok) next_state = dsm_pkg::DSM_SLEEP;   // see [RULE7]
				else if (!vdd_ok) next_state = dsm_pkg::DSM_POWER_OFF;
				else if (bat_ok && por_done) next_state = dsm_pkg::DSM_NORMAL; // see [RULE1]
			end
			dsm_pkg::DSM_SLEEP:
				if (vdd_ok) next_state = dsm_pkg::DSM_POR;               // see [RULE7]
				else if (!bat_ok) next_state = dsm_pkg::DSM_POWER_OFF;
			dsm_pkg::DSM_NORMAL:
				if (!vdd_ok) next_state = dsm_pkg::DSM_SLEEP;            // see [RULE7]
				else if (!bat_ok) next_state = dsm_pkg::DSM_POR;
			default: next_state = dsm_pkg::DSM_POWER_OFF;
		endcase
	end
	// supplies must stand steady for the whole filter; any dip restarts it
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state   <= dsm_pkg::DSM_POWER_OFF;
			por_cnt <= '0;
		end else begin
			state <= next_state;
			if (state != dsm_pkg::DSM_POR || !(bat_ok && vdd_ok)) por_cnt <= '0; // see [RULE2]
			else if (!por_done) por_cnt <= por_cnt + PW'(1);
		end
	end
	wire normal  = (state == dsm_pkg::DSM_NORMAL);
	wire def_ld  = !normal;   // defaults held outside normal, see [RULE22] [RULE8]

	// mode register
	logic [`DSM_MODE_W-1:0] mode;
	logic [NO-1:0]          spi_cmd;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode    <= `DSM_MODE_RST;
			spi_cmd <= '0;
		end else if (def_ld) begin
			mode    <= `DSM_MODE_RST;   // see [RULE22]
			spi_cmd <= '0;              // see [RULE8]
		end else begin
			if (i_mode_wr) mode <= i_mode_word;     // see [RULE13] [RULE5]
			if (i_spi_cmd_wr) spi_cmd <= i_spi_cmd; // see [RULE5]
		end
	end
	wire [N_CH-1:0] general_gate_mode  = mode[`DSM_GENERAL_GATE_MODE_LSB +: N_CH]; // see [RULE14] [RULE12]
	wire            v10   = mode[V10_BIT];
	wire            retry = mode[RETRY_BIT];
	wire [N_CH-1:0] pwm_en = mode[`DSM_PWM_LSB +: N_CH] & general_gate_mode; // see [RULE23]

	// shutdown sources and request per output
	wire [N_CH-1:0] v10_stop = {nominal_current_flag_in, max_current_flag_in, nominal_current_flag_in, max_current_flag_in}; // see [RULE17]
	wire [N_CH-1:0] max_stop = v10 ? v10_stop : i_max_current_cmp;   // see [RULE15]
	logic [NO-1:0] req;
	logic [NO-1:0] req_d;
	logic [NO-1:0] latch_off;
	logic [NO-1:0] uv_block;
	genvar g;
	generate
		for (g = 0; g < N_CH; g++) begin : g_ch
			// ignition ignores spi bit; general ORs it and may pwm
			assign req[g] = general_gate_mode[g] ?
				((gin[g] | spi_cmd[N_CH+g]) & (!pwm_en[g] | i_pwm_wave[g])) :
				gin[g];                                    // see [RULE21] [RULE24]
			assign req[N_CH+g] = din[g] | spi_cmd[g];  // see [RULE24]
		end
	endgenerate

	// latched shutdowns clear once the request is dropped; the output returns when it is raised again
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_d     <= '0;
			latch_off <= '0;
			uv_block  <= '0;
		end else begin
			req_d <= req;
			latch_off[N_CH-1:0] <= (latch_off[N_CH-1:0] & req[N_CH-1:0]) |
				(max_stop & req[N_CH-1:0]);               // see [RULE15] [RULE17]
			latch_off[NO-1:N_CH] <= '0;
			if (bat_flt && retry) uv_block <= '1;           // see [RULE19]
			// leaving normal drops the block with the other control state, see [RULE22]
			else uv_block <= uv_block & ~(req & ~req_d) & req & {NO{normal}};
		end
	end

	// output gate forces all off but leaves spi alone
	wire allow = normal && !gate_n && !bat_flt; // see [RULE3] [RULE4] [RULE6] [RULE18] [RULE20]
	wire [NO-1:0] next_out = allow ? (req & ~latch_off & ~uv_block) : '0;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_gate_drive_outputs <= '0;
			o_injector_outputs   <= '0;
		end else begin
			o_gate_drive_outputs <= next_out[N_CH-1:0];
			o_injector_outputs   <= next_out[NO-1:N_CH];
		end
	end

	// current flags: outputs normally, inputs in ten-cylinder mode
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_max_current_flag     <= 1'b0;
			o_nominal_current_flag <= 1'b0;
		end else begin
			o_max_current_flag     <= |(i_max_current_cmp & ~general_gate_mode);
			o_nominal_current_flag <= |(i_nominal_current_cmp & ~general_gate_mode);
		end
	end
	assign o_max_current_flag_oe     = normal && !v10; // see [RULE16]
	assign o_nominal_current_flag_oe = normal && !v10; // see [RULE16]

	// configuration: mode fields reload defaults outside normal; the other settings are tied to their defaults in every state
	assign o_general_gate_mode   = general_gate_mode;
	assign o_ten_cylinder_mode   = v10;
	assign o_pwm_enable          = pwm_en;
	assign o_open_load_detect_en = 1'b1;              // see [RULE8]
	assign o_max_dac_sel         = `DSM_MAX_CURRENT_FLAG_DAC_RST; // see [RULE9]
	assign o_nom_dac_sel         = `DSM_NOMINAL_CURRENT_FLAG_DAC_RST; // see [RULE9]
	assign o_end_spark_sel       = `DSM_ENDSPK_RST;   // see [RULE9]
	assign o_open_sec_sel        = `DSM_OSFLT_RST;    // see [RULE10]
	assign o_dwell_sel           = `DSM_DWELL_RST;    // see [RULE10]
	assign o_soft_shutdown_en    = 1'b0;              // see [RULE11]
	assign o_low_clamp_en        = 1'b0;              // see [RULE11]
	assign o_overlap_offset_en   = 1'b0;              // see [RULE11]
	assign o_spi_ready           = normal;            // see [RULE5]
	assign o_state               = state;
endmodule // dsm_ctrl

// ---- src/dsm_params.svh ----
// constants for the driver state and mode control block
// assumes a 10 MHz logic clock
`ifndef DSM_PARAMS_SVH
`define DSM_PARAMS_SVH
`define DSM_CLK_NS          100
`define DSM_POR_FILTER_NS   2000
`define DSM_POR_FILTER_CYC  ((`DSM_POR_FILTER_NS + `DSM_CLK_NS - 1) / `DSM_CLK_NS)
`define DSM_MODE_W          16
`define DSM_PWM_LSB         0
`define DSM_GENERAL_GATE_MODE_LSB        8
`define DSM_V10_BIT         12
`define DSM_RETRY_BIT       13
`define DSM_MODE_RST        16'h0000
`define DSM_MAX_CURRENT_FLAG_DAC_RST    2'h3
`define DSM_NOMINAL_CURRENT_FLAG_DAC_RST    2'h1
`define DSM_ENDSPK_RST      2'h1
`define DSM_OSFLT_RST       2'h3
`define DSM_DWELL_RST       3'h4
`endif

// ---- src/dsm_pkg.sv ----
// types for the driver state and mode control block
// assumes dsm_params.svh is available
package dsm_pkg;
	typedef enum logic [1:0] {
		DSM_POWER_OFF,
		DSM_POR,
		DSM_SLEEP,
		DSM_NORMAL
	} dsm_state_t;
endpackage

// ---- verification/dsm_ctrl_props.sv ----
// concurrent checks on the ports of dsm_ctrl
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ns
module dsm_ctrl_props (
	input wire logic                i_ref_clk,
	input wire logic                i_rst_n,
	input wire logic                i_battery_fault,
	input wire logic                i_output_gate_n,
	input wire logic                i_mode_wr,
	input wire logic [15:0]         i_mode_word,
	input wire logic [3:0]          o_gate_drive_outputs,
	input wire logic [3:0]          o_injector_outputs,
	input wire logic [3:0]          o_general_gate_mode,
	input wire logic                o_ten_cylinder_mode,
	input wire logic [3:0]          o_pwm_enable,
	input wire logic                o_max_current_flag_oe,
	input wire logic                o_open_load_detect_en,
	input wire logic [1:0]          o_max_dac_sel,
	input wire logic [1:0]          o_nom_dac_sel,
	input wire logic [1:0]          o_end_spark_sel,
	input wire logic [1:0]          o_open_sec_sel,
	input wire logic [2:0]          o_dwell_sel,
	input wire logic                o_soft_shutdown_en,
	input wire logic                o_low_clamp_en,
	input wire logic                o_overlap_offset_en,
	input wire logic                o_spi_ready,
	input wire dsm_pkg::dsm_state_t o_state
);
	localparam dsm_pkg::dsm_state_t NRM = dsm_pkg::DSM_NORMAL;
	wire [7:0] outs = {o_gate_drive_outputs, o_injector_outputs};
	wire [8:0] mode = {o_general_gate_mode, o_ten_cylinder_mode, o_pwm_enable};
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// one cycle of grace: outputs are registered behind the state
	property p_idle; o_state != NRM && $past(o_state) != NRM |-> outs == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("outputs on outside normal");
	property p_gate; i_output_gate_n [*4] |=> outs == 8'h00; endproperty
	a_gate: assert property (p_gate) else $error("gate pin high left outputs on");
	property p_fault; i_battery_fault [*4] |=> outs == 8'h00; endproperty
	a_fault: assert property (p_fault) else $error("battery fault left outputs on");
	property p_spi; o_spi_ready == (o_state == NRM); endproperty
	a_spi: assert property (p_spi) else $error("spi ready wrong");
	property p_oe; o_max_current_flag_oe == (o_state == NRM && !o_ten_cylinder_mode); endproperty
	a_oe: assert property (p_oe) else $error("flag pin direction wrong");
	property p_mode; i_mode_wr && o_state == NRM ##1 o_state == NRM |->
		mode == {$past(i_mode_word[11:8]), $past(i_mode_word[12]),
			$past(i_mode_word[3:0] & i_mode_word[11:8])};
	endproperty
	a_mode: assert property (p_mode) else $error("mode word not loaded");
	property p_dflt; {o_open_load_detect_en, o_soft_shutdown_en, o_low_clamp_en,
		o_overlap_offset_en, o_max_dac_sel, o_nom_dac_sel, o_end_spark_sel,
		o_open_sec_sel, o_dwell_sel} == 15'h46bc; endproperty
	a_dflt: assert property (p_dflt) else $error("default settings wrong");
	property p_reload; o_state != NRM && $past(o_state) != NRM |-> mode == 9'h000; endproperty
	a_reload: assert property (p_reload) else $error("mode not back to default");
	property p_enter; $rose(o_state == NRM) |-> $past(o_state) == dsm_pkg::DSM_POR; endproperty
	a_enter: assert property (p_enter) else $error("normal entered without por");
endmodule // dsm_ctrl_props
bind dsm_ctrl dsm_ctrl_props u_props (.*);

// ---- verification/dsm_host_model.sv ----
// host side: issues decoded mode and command words as one-cycle strobes
// assumes the block clock; strobes move on falling edges
`timescale 1ns/1ns
module dsm_host_model (
	input  wire logic  i_clk,
	output logic       o_mode_wr,
	output logic [15:0] o_mode_word,
	output logic       o_cmd_wr,
	output logic [7:0] o_cmd
);
	initial {o_mode_wr, o_cmd_wr, o_mode_word, o_cmd} = '0;
	// idle word inverted so a stale value never passes for a write
	task wr_mode(input logic [15:0] w);
		@(negedge i_clk);
		o_mode_word = w;
		o_mode_wr = 1'b1;
		@(negedge i_clk);
		o_mode_wr = 1'b0;
		o_mode_word = ~w;
	endtask
	task wr_cmd(input logic [7:0] w);
		@(negedge i_clk);
		o_cmd = w;
		o_cmd_wr = 1'b1;
		@(negedge i_clk);
		o_cmd_wr = 1'b0;
		o_cmd = ~w;
	endtask
endmodule // dsm_host_model

// ---- verification/dsm_ctrl_bench.sv ----
// self-checking bench for dsm_ctrl with random and corner cases
// assumes the host model and the bound checker
`timescale 1ns/1ns
module dsm_ctrl_bench;
	logic       clk, rst_n, bat, lgc, flt, gate_n, mxf, nmf;
	logic [3:0] gin, din, mxc, nmc, pwm, gd, inj, gp, pe;
	logic       mwr, cwr, tc, oe, mf, nf;
	logic [15:0] mw, m;
	logic [7:0]  cw, c;
	dsm_pkg::dsm_state_t st;
	integer seed = 79870, bad_count = 0, check_count = 0, i;
	dsm_host_model host (.i_clk(clk), .o_mode_wr(mwr), .o_mode_word(mw), .o_cmd_wr(cwr), .o_cmd(cw));
	dsm_ctrl DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_battery_supply_ok(bat),
		.i_logic_supply_ok(lgc), .i_battery_fault(flt), .i_output_gate_n(gate_n),
		.i_gate_parallel_inputs(gin), .i_injector_parallel_inputs(din), .i_spi_cmd_wr(cwr),
		.i_spi_cmd(cw), .i_mode_wr(mwr), .i_mode_word(mw), .i_max_current_cmp(mxc),
		.i_nominal_current_cmp(nmc), .i_pwm_wave(pwm), .i_max_current_flag_in(mxf),
		.i_nominal_current_flag_in(nmf), .o_gate_drive_outputs(gd), .o_injector_outputs(inj),
		.o_max_current_flag(mf), .o_max_current_flag_oe(oe), .o_nominal_current_flag(nf),
		.o_nominal_current_flag_oe(), .o_general_gate_mode(gp), .o_ten_cylinder_mode(tc),
		.o_pwm_enable(pe), .o_open_load_detect_en(), .o_max_dac_sel(), .o_nom_dac_sel(),
		.o_end_spark_sel(), .o_open_sec_sel(), .o_dwell_sel(), .o_soft_shutdown_en(),
		.o_low_clamp_en(), .o_overlap_offset_en(), .o_spi_ready(), .o_state(st));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("mismatches %0d checks %0d", bad_count, check_count);
		if (bad_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// bounded wait: por filter plus pin sync
	task norm;
		for (int k = 0; k < 60 && st !== dsm_pkg::DSM_NORMAL; k++) cyc(1);
	endtask
	function logic [7:0] ex(input logic [15:0] w, input logic [7:0] q);
		return {gin | (q[7:4] & w[11:8]), din | q[3:0]};
	endfunction
	initial begin
		{rst_n, flt, gate_n, mxf, nmf, gin, din, mxc, nmc, pwm} = '0;
		{bat, lgc} = 2'h3;
		cyc(4);
		rst_n = 1'b1;
		norm();
		chk({gd, inj, gp, pe}, 16'h0000);
		for (i = 0; i < 24; i++) begin
			m = $random(seed) & 16'h0f00;
			c = $random(seed);
			{gin, din, pwm} = $random(seed);
			host.wr_mode(m);
			host.wr_cmd(c);
			cyc(4);
			chk({gd, inj}, ex(m, c));
			chk(gp, m[11:8]);
		end
		host.wr_mode(16'h0f05);
		cyc(2);
		chk(pe, 4'h5);
		gate_n = 1'b1;
		host.wr_mode(16'h0000);
		cyc(4);
		chk({gd, inj, gp}, 12'h000);
		gate_n = 1'b0;
		cyc(4);
		chk({gd, inj}, ex(16'h0000, c));
		{gin, din} = 8'hf0;
		host.wr_cmd(8'h00);
		flt = 1'b1;
		cyc(4);
		chk({gd, inj}, 8'h00);
		flt = 1'b0;
		cyc(4);
		chk({gd, inj}, 8'hf0);
		host.wr_mode(16'h2000);
		flt = 1'b1;
		cyc(4);
		flt = 1'b0;
		cyc(4);
		chk({gd, inj}, 8'h00);
		gin = 4'h0;
		cyc(4);
		gin = 4'hf;
		cyc(4);
		chk({gd, inj}, 8'hf0);
		host.wr_mode(16'h0f00);
		mxc = 4'h2;
		cyc(2);
		chk(gd, 4'hd);
		mxc = 4'h0;
		host.wr_mode(16'h1000);
		gin = 4'h0;
		cyc(4);
		gin = 4'hf;
		mxf = 1'b1;
		cyc(6);
		chk({gd, oe, tc}, 6'h29);
		{mxf, nmf, gin} = 6'h10;
		cyc(4);
		gin = 4'hf;
		cyc(6);
		chk(gd, 4'h5);
		lgc = 1'b0;
		cyc(4);
		chk({st, gd, inj, gp}, {dsm_pkg::DSM_SLEEP, 12'h000});
		lgc = 1'b1;
		cyc(4);
		chk(st, dsm_pkg::DSM_POR);
		norm();
		chk({st, tc, gp}, {dsm_pkg::DSM_NORMAL, 5'h00});
		// ignition drivers report comparator levels on the flag pins
		{mxc, nmc} = 8'h14;
		cyc(2);
		chk({mf, nf}, 2'h3);
		{mxc, nmc} = 8'h00;
		bat = 1'b0;
		cyc(4);
		chk({st, gd, inj}, {dsm_pkg::DSM_POR, 8'h00});
		bat = 1'b1;
		norm();
		chk(st, dsm_pkg::DSM_NORMAL);
		complete_run();
	end
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
endmodule // dsm_ctrl_bench
